// file: hw/transceiver_mode_sequencer.sv
/*
  Operating-mode sequencer of a sub-GHz transceiver with an APB register
  slave. Assumes synthesizer lock, RC oscillator, signal detect and data
  pins arrive asynchronously; the transmit begin condition comes from
  logic on core_clk.
*/
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "xcvr_defs.svh"
module transceiver_mode_sequencer #(
  parameter int ANA_CYC        = `ANA_CYC,
  parameter int PLL_RELOCK_CYC = `PLL_RELOCK_CYC,
  parameter int LIS_RES1_TICKS = `LIS_RES1_NS / `RC_PERIOD_NS,
  parameter int LIS_RES2_TICKS = `LIS_RES2_NS / `RC_PERIOD_NS,
  parameter int LIS_RES3_TICKS = `LIS_RES3_NS / `RC_PERIOD_NS
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        synthLockIn,
  input  wire logic        rcClkIn,
  input  wire logic        signalDetectIn,
  input  wire logic        demodDataIn,
  input  wire logic        serialDataIn,
  input  wire logic        txBeginCond,
  output logic             pllLockPin_q,
  output logic             mode_reached_flag_q,
  output logic             transmitter_ready_flag_q,
  output logic             receiver_ready_flag_q,
  output logic             xtalEnable_q,
  output logic             synthEnable_q,
  output logic             ampRegEnable_q,
  output logic             ampRampEnable_q,
  output logic             rxEnable_q,
  output logic             rcOscOnly_q,
  output logic             bitClockOut_q,
  output logic             txModData_q,
  output logic             serialDataOut_q,
  output logic             serialDataOe_n_q,
  output logic             preambleOn_q,
  output logic             packetActive_q,
  output logic             dataValid_q
);
  import xcvr_pkg::*;

  localparam int XtalCyc = `XTAL_WAKE_CYC;
  localparam int TxRegCyc = `TX_REG_CYC;
  // A literal cannot be part-selected, so the reset word is named first
  localparam logic [7:0] OpModeRst = `OPMODE_RST;

  seqState_type state_q;
  seqState_type stateD;
  mode_type     modeField_q;
  logic         seqDisable_q;
  logic         listenEn_q;
  logic         periodic_listen_abort_q;
  logic [19:0]  bitCfg_q;
  logic [15:0]  txCfg_q;
  logic [27:0]  rxCfg_q;
  logic [19:0]  lisCfg_q;
  logic [4:0]   sync1_q;
  logic [4:0]   sync2_q;
  logic         rcPrev_q;
  logic [31:0]  cnt_q;
  logic [31:0]  limit;
  logic [20:0]  resCnt_q;
  logic [7:0]   coefCnt_q;
  logic [15:0]  bitCnt_q;
  logic [3:0]   preambleBits_q;
  logic [31:0]  rdData;
  logic         hit;
  logic         opWr;
  logic [31:0]  bitCyc;
  logic [31:0]  quarter;
  logic [31:0]  cfCyc;
  logic [31:0]  dccCyc;
  logic [31:0]  rssiCyc;
  logic [31:0]  afcCyc;
  logic [31:0]  rxDelay;
  logic [31:0]  rampCyc;
  logic         lockSync;
  logic         rcRise;
  logic         sigSync;
  logic         timedDone;
  logic         bitTick;
  logic         stable;
  logic         lisDone;
  logic         needSync;
  logic [20:0]  resLimit;
  logic [7:0]   coefLimit;
  logic [1:0]   resSel;

  // Every asynchronous input gets two flops; only the second one is read
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      rcPrev_q <= 1'b0;
    end else begin
      sync1_q <= {serialDataIn, demodDataIn, signalDetectIn, rcClkIn, synthLockIn};
      sync2_q <= sync1_q;
      rcPrev_q <= sync2_q[1];
    end
  end
  assign lockSync = sync2_q[0];
  assign rcRise = sync2_q[1] & ~rcPrev_q;
  assign sigSync = sync2_q[2];

  // APB: zero-wait answer, read data captured in the setup cycle
  always_comb begin
    hit = 1'b1;
    rdData = 32'h0000_0000;
    case (paddr)
      `ADDR_OPMODE: rdData = {24'h000000, seqDisable_q, listenEn_q, periodic_listen_abort_q,
                              modeField_q, 2'h0};
      `ADDR_BITCFG: rdData = {12'h000, bitCfg_q};
      `ADDR_TXCFG:  rdData = {16'h0000, txCfg_q};
      `ADDR_RXCFG:  rdData = {4'h0, rxCfg_q};
      `ADDR_LISCFG: rdData = {12'h000, lisCfg_q};
      `ADDR_STATUS: rdData = {26'h0000000, dataValid_q, packetActive_q, pllLockPin_q,
                              receiver_ready_flag_q, transmitter_ready_flag_q, mode_reached_flag_q};
      default:      hit = 1'b0;
    endcase
  end
  assign opWr = psel & penable & pready & pwrite & (paddr == `ADDR_OPMODE);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rdData;
        pslverr <= ~hit;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      modeField_q <= OpModeRst[`OP_MODE_HI:`OP_MODE_LO];
      seqDisable_q <= OpModeRst[`OP_SEQDIS];
      listenEn_q <= OpModeRst[`OP_LISEN];
      periodic_listen_abort_q <= OpModeRst[`OP_LISABT];
    end else if (opWr) begin
      seqDisable_q <= pwdata[`OP_SEQDIS];
      listenEn_q <= pwdata[`OP_LISEN];
      periodic_listen_abort_q <= pwdata[`OP_LISABT];
      if (pwdata[`OP_MODE_HI:`OP_MODE_LO] <= `MODE_RX) begin
        modeField_q <= pwdata[`OP_MODE_HI:`OP_MODE_LO];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bitCfg_q <= `BITCFG_RST;
      txCfg_q <= `TXCFG_RST;
      rxCfg_q <= `RXCFG_RST;
      lisCfg_q <= `LISCFG_RST;
    end else if (psel & penable & pready & pwrite) begin
      if (paddr == `ADDR_BITCFG) bitCfg_q <= pwdata[19:0];
      if (paddr == `ADDR_TXCFG) txCfg_q <= pwdata[15:0];
      if (paddr == `ADDR_RXCFG) rxCfg_q <= pwdata[27:0];
      if (paddr == `ADDR_LISCFG) lisCfg_q <= pwdata[19:0];
    end
  end

  // Start delays; bandwidth terms come in as cycles of one over four bandwidths
  always_comb begin
    bitCyc = {16'h0000, bitCfg_q[15:0]};
    quarter = {16'h0000, rxCfg_q[15:0]};
    rampCyc = {16'h0000, txCfg_q} + {18'h00000, txCfg_q[15:2]};
    cfCyc = quarter * (bitCfg_q[`BC_OOK] ? `CF_OOK : `CF_FSK);
    if (rxCfg_q[19:16] < `DCC_MIN_EXP) begin
      dccCyc = quarter * `DCC_MIN;
    end else begin
      dccCyc = quarter << rxCfg_q[19:16];
    end
    rssiCyc = `RSSI_MUL * {24'h000000, rxCfg_q[27:20]} * quarter;
    afcCyc = 32'h0000_0000;
    if (bitCfg_q[`BC_AFC]) begin
      afcCyc = `AFC_BITS * bitCyc + 32'(PLL_RELOCK_CYC);
    end
    rxDelay = 32'(ANA_CYC) + cfCyc + dccCyc + rssiCyc + afcCyc;
  end

  always_comb begin
    case (state_q)
      ST_XO_WAKE: limit = 32'(XtalCyc);
      ST_TX_REG:  limit = 32'(TxRegCyc);
      ST_TX_RAMP: limit = rampCyc;
      ST_TX_HALF: limit = {1'b0, bitCyc[31:1]};
      ST_RX_WAKE: limit = rxDelay;
      default:    limit = 32'h0000_0000;
    endcase
  end
  assign timedDone = (cnt_q + 32'h1) >= limit;

  function automatic seqState_type finalOf(input mode_type m);
    case (m)
      `MODE_SLEEP: finalOf = ST_SLEEP;
      `MODE_STBY:  finalOf = ST_STBY;
      `MODE_FS:    finalOf = ST_FS;
      `MODE_TX:    finalOf = ST_TX;
      default:     finalOf = ST_RX;
    endcase
  endfunction

  // Next waypoint toward the requested mode from a settled point
  function automatic seqState_type stepTo(input mode_type m, input logic xo,
                                          input logic syn, input logic direct);
    if (direct) stepTo = finalOf(m);
    else if (m == `MODE_SLEEP) stepTo = ST_SLEEP;
    else if (!xo) stepTo = ST_XO_WAKE;
    else if (m == `MODE_STBY) stepTo = ST_STBY;
    else if (!syn) stepTo = ST_FS_WAKE;
    else if (m == `MODE_FS) stepTo = ST_FS;
    else if (m == `MODE_TX) stepTo = ST_TX_REG;
    else stepTo = ST_RX_WAKE;
  endfunction

  assign stable = (state_q == ST_SLEEP) || (state_q == ST_STBY) || (state_q == ST_FS)
                  || (state_q == ST_TX) || (state_q == ST_RX);

  always_comb begin
    stateD = state_q;
    case (state_q)
      ST_SLEEP, ST_STBY, ST_FS, ST_TX, ST_RX: begin
        if (listenEn_q) begin
          stateD = ST_LIS_IDLE;
        end else if (finalOf(modeField_q) != state_q) begin
          stateD = stepTo(modeField_q, state_q != ST_SLEEP,
                          state_q != ST_SLEEP && state_q != ST_STBY, seqDisable_q);
        end
      end
      ST_XO_WAKE: if (timedDone) stateD = ST_STBY;
      ST_FS_WAKE: if (lockSync) stateD = ST_FS;
      ST_TX_REG:  if (timedDone) stateD = ST_TX_RAMP;
      ST_TX_RAMP: if (timedDone) stateD = ST_TX_HALF;
      ST_TX_HALF: if (timedDone) stateD = ST_TX;
      ST_RX_WAKE: if (timedDone) stateD = ST_RX;
      ST_LIS_IDLE: if (lisDone) stateD = ST_LIS_RX;
      ST_LIS_RX: begin
        if (sigSync) stateD = ST_LIS_KEEP;
        else if (lisDone) stateD = ST_LIS_IDLE;
      end
      default: stateD = state_q;
    endcase
    // Listen is left only through the abort write; crystal restarts from cold
    if ((state_q == ST_LIS_IDLE || state_q == ST_LIS_RX || state_q == ST_LIS_KEEP)
        && !listenEn_q && periodic_listen_abort_q) begin
      stateD = stepTo(modeField_q, 1'b0, 1'b0, seqDisable_q);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_SLEEP;
      cnt_q <= 32'h0000_0000;
    end else begin
      state_q <= stateD;
      cnt_q <= (stateD != state_q) ? 32'h0000_0000 : cnt_q + 32'h1;
    end
  end

  // Listen phase timing counts RC oscillator edges
  always_comb begin
    resSel = (state_q == ST_LIS_IDLE) ? lisCfg_q[19:18] : lisCfg_q[17:16];
    coefLimit = (state_q == ST_LIS_IDLE) ? lisCfg_q[15:8] : lisCfg_q[7:0];
    if (coefLimit == 8'h00) coefLimit = 8'h01;
    case (resSel)
      2'h2:    resLimit = 21'(LIS_RES2_TICKS);
      2'h3:    resLimit = 21'(LIS_RES3_TICKS);
      default: resLimit = 21'(LIS_RES1_TICKS);
    endcase
  end
  assign lisDone = coefCnt_q >= coefLimit;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      resCnt_q <= 21'h000000;
      coefCnt_q <= 8'h00;
    end else if (stateD != state_q) begin
      resCnt_q <= 21'h000000;
      coefCnt_q <= 8'h00;
    end else if (rcRise) begin
      if (resCnt_q + 21'h1 >= resLimit) begin
        resCnt_q <= 21'h000000;
        coefCnt_q <= coefCnt_q + 8'h01;
      end else begin
        resCnt_q <= resCnt_q + 21'h1;
      end
    end
  end

  // Bit timing for the bit clock and the preamble count
  assign bitTick = (bitCnt_q + 16'h1) >= bitCfg_q[15:0];
  assign needSync = bitCfg_q[`BC_PACKET] | bitCfg_q[`BC_BITSYNC];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bitCnt_q <= 16'h0000;
      preambleBits_q <= 4'h0;
    end else if (state_q != ST_TX && state_q != ST_RX) begin
      bitCnt_q <= 16'h0000;
      preambleBits_q <= 4'h0;
    end else begin
      bitCnt_q <= bitTick ? 16'h0000 : bitCnt_q + 16'h1;
      if (bitTick && state_q == ST_RX && preambleBits_q < `SYNC_BITS) begin
        preambleBits_q <= preambleBits_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_reached_flag_q <= 1'b0;
      transmitter_ready_flag_q <= 1'b0;
      receiver_ready_flag_q <= 1'b0;
      pllLockPin_q <= 1'b0;
    end else begin
      mode_reached_flag_q <= listenEn_q ? (state_q == ST_LIS_IDLE || state_q == ST_LIS_RX
                                   || state_q == ST_LIS_KEEP)
                                : (stable && state_q == finalOf(modeField_q));
      transmitter_ready_flag_q <= state_q == ST_TX;
      receiver_ready_flag_q <= state_q == ST_RX || state_q == ST_LIS_KEEP;
      pllLockPin_q <= lockSync;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      xtalEnable_q <= 1'b0;
      synthEnable_q <= 1'b0;
      ampRegEnable_q <= 1'b0;
      ampRampEnable_q <= 1'b0;
      rxEnable_q <= 1'b0;
      rcOscOnly_q <= 1'b0;
    end else begin
      xtalEnable_q <= state_q != ST_SLEEP && state_q != ST_LIS_IDLE;
      synthEnable_q <= !(state_q inside {ST_SLEEP, ST_XO_WAKE, ST_STBY, ST_LIS_IDLE});
      ampRegEnable_q <= state_q inside {ST_TX_REG, ST_TX_RAMP, ST_TX_HALF, ST_TX};
      ampRampEnable_q <= state_q inside {ST_TX_RAMP, ST_TX_HALF, ST_TX};
      rxEnable_q <= state_q inside {ST_RX_WAKE, ST_RX, ST_LIS_RX, ST_LIS_KEEP};
      rcOscOnly_q <= state_q == ST_LIS_IDLE;
    end
  end

  // Data path; the serial pin turns around only in receive
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bitClockOut_q <= 1'b0;
      txModData_q <= 1'b0;
      serialDataOut_q <= 1'b0;
      serialDataOe_n_q <= 1'b1;
      preambleOn_q <= 1'b0;
      packetActive_q <= 1'b0;
      dataValid_q <= 1'b0;
    end else begin
      bitClockOut_q <= (state_q == ST_TX || (state_q == ST_RX && bitCfg_q[`BC_BITSYNC]))
                       && bitCnt_q < {1'b0, bitCfg_q[15:1]};
      txModData_q <= state_q == ST_TX && !bitCfg_q[`BC_PACKET] && sync2_q[4];
      serialDataOut_q <= state_q == ST_RX && sync2_q[3];
      serialDataOe_n_q <= state_q != ST_RX;
      preambleOn_q <= state_q == ST_TX && bitCfg_q[`BC_PACKET];
      // Preamble length itself belongs to the packet engine behind this flag
      if (state_q != ST_TX || !bitCfg_q[`BC_PACKET]) packetActive_q <= 1'b0;
      else if (txBeginCond) packetActive_q <= 1'b1;
      dataValid_q <= state_q == ST_RX && (!needSync || preambleBits_q >= `SYNC_BITS);
    end
  end

  a_reserved_mode: assert property (@(posedge core_clk) disable iff (reset)
    (opWr && pwdata[`OP_MODE_HI:`OP_MODE_LO] > `MODE_RX) |=> $stable(modeField_q))
    else $error("reserved mode code changed the mode");
  a_listen_select: assert property (@(posedge core_clk) disable iff (reset)
    (stable && listenEn_q) |=> state_q == ST_LIS_IDLE)
    else $error("listen enable did not select listen");
  a_seq_direct: assert property (@(posedge core_clk) disable iff (reset)
    (stable && seqDisable_q && !listenEn_q && finalOf(modeField_q) != state_q)
    |=> state_q == finalOf($past(modeField_q)))
    else $error("direct mode change took steps");
  a_xo_first: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == ST_SLEEP && !seqDisable_q && !listenEn_q && modeField_q != `MODE_SLEEP)
    |=> state_q == ST_XO_WAKE)
    else $error("sleep exit did not start the crystal");
  a_fs_wait_lock: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == ST_FS_WAKE && !lockSync) |=> state_q == ST_FS_WAKE)
    else $error("synth wake left before lock");
  a_amp_order: assert property (@(posedge core_clk) disable iff (reset)
    $rose(ampRampEnable_q) |-> ampRegEnable_q && !bitClockOut_q && $past(ampRegEnable_q))
    else $error("amplifier ramp before regulator");
  a_lock_pin: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == ST_FS_WAKE ##1 state_q == ST_FS) |-> pllLockPin_q)
    else $error("lock pin low at synth ready");
  a_tx_reg_time: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == ST_TX_REG ##1 state_q == ST_TX_RAMP) |-> $past(cnt_q) == TxRegCyc - 1)
    else $error("regulator wake time wrong");
  a_tx_flags: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == ST_TX && modeField_q == `MODE_TX && !listenEn_q) |=> transmitter_ready_flag_q && mode_reached_flag_q)
    else $error("transmit ready flags missing");
  a_rx_ready: assert property (@(posedge core_clk) disable iff (reset)
    $rose(receiver_ready_flag_q) |-> $past(state_q) == ST_RX || $past(state_q) == ST_LIS_KEEP)
    else $error("receiver ready without receive");
  a_sync_bits: assert property (@(posedge core_clk) disable iff (reset)
    ($rose(dataValid_q) && needSync) |-> $past(preambleBits_q) == `SYNC_BITS)
    else $error("data valid before preamble lock");
  a_ready_moving: assert property (@(posedge core_clk) disable iff (reset)
    (!stable && !listenEn_q) |=> !mode_reached_flag_q)
    else $error("mode ready during transition");
endmodule

// file: shared/xcvr_defs.svh
/*
  Register map, field positions, reset values and timing counts of the
  transceiver mode sequencer. Assumes a 250 MHz core clock and an APB
  master with 32-bit data.
*/
// How it works
// - Without listen, mode 000..100 means sleep, standby, synth, transmit, receive
// - Listen enable set selects listen whatever the mode; host sets it in standby
// - Sequencer steps sub-blocks in order; sequencer disable jumps straight there
// - Sleep to transmit goes standby with crystal, then synth, then transmit on lock
// - Transmit wakes amplifier regulator, then ramps amplifier, then starts bit clock
// - Lock pin goes high once the synthesizer loop is locked
// - Transmit start delay is 5 us plus 1.25 ramp time plus half a bit
// - Mode-ready and transmitter-ready flags say the transmitter takes data
// - Packet transmit sends preamble at ready, packet starts on begin condition
// - Receiver start allows 20 us analog front-end delay
// - Receiver start allows filter delay 21 (or 34 on-off) over four bandwidths
// - Receiver start allows DC-cut delay max(8, power-of-two) over four bandwidths
// - After frequency correction allow synth relock of 5 over 300 kHz
// - Each frequency-correction sample lasts four bit periods
// - Each strength sample lasts 2 int(4 bandwidth bit) over four bandwidths
// - Receiver-ready flag says the receiver finished its start
// - With bit sync, data is valid only after 12 preamble bits
// - Continuous receive without bit sync gives data right after receiver ready
// - Listen idles on the RC oscillator, wakes receiver, keeps it on a signal
// - Listen phase lengths are coefficient 1..255 times 64us, 4.1ms or 262ms
`ifndef XCVR_DEFS_SVH
`define XCVR_DEFS_SVH

`define ADDR_OPMODE 8'h00
`define ADDR_BITCFG 8'h04
`define ADDR_TXCFG  8'h08
`define ADDR_RXCFG  8'h0C
`define ADDR_LISCFG 8'h10
`define ADDR_STATUS 8'h14

`define OP_SEQDIS  7
`define OP_LISEN   6
`define OP_LISABT  5
`define OP_MODE_HI 4
`define OP_MODE_LO 2
`define MODE_SLEEP 3'h0
`define MODE_STBY  3'h1
`define MODE_FS    3'h2
`define MODE_TX    3'h3
`define MODE_RX    3'h4
`define OPMODE_RST 8'h04

`define BC_OOK     16
`define BC_BITSYNC 17
`define BC_PACKET  18
`define BC_AFC     19
`define BITCFG_RST 20'h00100
`define TXCFG_RST  16'h0010
`define RXCFG_RST  28'h0010010
`define LISCFG_RST 20'h50101

`define CLK_PERIOD_NS  4
`define TX_REG_NS      5000
`define TX_REG_CYC     ((`TX_REG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ANA_NS         20000
`define ANA_CYC        ((`ANA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_RELOCK_NUM 5
`define PLL_BW_KHZ     300
`define PLL_RELOCK_CYC ((`PLL_RELOCK_NUM * 1000000 + `PLL_BW_KHZ * `CLK_PERIOD_NS - 1) / (`PLL_BW_KHZ * `CLK_PERIOD_NS))
`define CF_FSK         32'h15
`define CF_OOK         32'h22
`define DCC_MIN        32'h8
`define DCC_MIN_EXP    4'h3
`define RSSI_MUL       32'h2
`define AFC_BITS       32'h4
`define SYNC_BITS      4'hC
`define XTAL_WAKE_CYC  1000
`define RC_PERIOD_NS   160
`define LIS_RES1_NS    64000
`define LIS_RES2_NS    4100000
`define LIS_RES3_NS    262000000

`endif

// file: shared/xcvr_pkg.sv
/*
  Types of the transceiver mode sequencer. Assumes nothing outside.
*/
package xcvr_pkg;
  typedef enum {
    ST_SLEEP, ST_XO_WAKE, ST_STBY, ST_FS_WAKE, ST_FS,
    ST_TX_REG, ST_TX_RAMP, ST_TX_HALF, ST_TX, ST_RX_WAKE, ST_RX,
    ST_LIS_IDLE, ST_LIS_RX, ST_LIS_KEEP
  } seqState_type;
  typedef logic [2:0] mode_type;
endpackage

// file: bench/host_model.sv
/* Host model: APB master and serial transmit data pin.
   Assumes xfer is called just after a rising edge of core_clk. */
`timescale 1ns/1ps
module host_model (
  input  wire logic        core_clk,
  input  wire logic        bitClk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  output logic             serialDataIn,
  output logic             hung
);
  int   seed = 32'h31FF95AD;
  int   rv;
  logic bitPrev = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata, serialDataIn, hung} = '0;
  // New bit on each bit clock rise keeps data stable for a whole bit
  always @(posedge core_clk) begin
    bitPrev <= bitClk;
    rv = $random(seed);
    if (bitClk && !bitPrev) serialDataIn <= rv[0];
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge core_clk);
    hung <= (n == 20);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// file: bench/transceiver_mode_sequencer_test.sv
/* Self-checking bench of the mode sequencer; reads are checked from a queue.
   Assumes the host model as APB master and a synthesizer that locks late. */
`timescale 1ns/1ps
module transceiver_mode_sequencer_test;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, hung, synthLockIn, rcClkIn;
  logic demodDataIn, serialDataIn, pllLockPin_q, mode_reached_flag_q, transmitter_ready_flag_q, receiver_ready_flag_q;
  logic xtalEnable_q, synthEnable_q, ampRegEnable_q, ampRampEnable_q, rxEnable_q, rcOscOnly_q;
  logic bitClockOut_q, txModData_q, serialDataOut_q, serialDataOe_n_q, bcPrev, txChk, rxChk;
  logic        sigDet, txBegin, preOn, pktAct, dataVal;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] expQ[$];
  logic [32:0] rstv[7] = '{33'h4, 33'h100, 33'h10, 33'h10010, 33'h50101, 33'h1, 33'h1_0000_0000};
  int          rxExp[2] = '{516, 724};
  int          mismatches = 0, nChecks = 0, lockCnt = 0, cyc = 0, seed = 32'h31FF95AD;
  int          rv, n, n1, i;
  wire  [6:0]  flags = {rcOscOnly_q, rxEnable_q, ampRampEnable_q, ampRegEnable_q,
                        receiver_ready_flag_q, transmitter_ready_flag_q, mode_reached_flag_q};
  transceiver_mode_sequencer #(.ANA_CYC(20), .PLL_RELOCK_CYC(20), .LIS_RES1_TICKS(5),
    .LIS_RES2_TICKS(10), .LIS_RES3_TICKS(20)) dut (.core_clk(core_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .synthLockIn(synthLockIn),
    .rcClkIn(rcClkIn), .signalDetectIn(sigDet), .demodDataIn(demodDataIn),
    .serialDataIn(serialDataIn), .txBeginCond(txBegin), .pllLockPin_q(pllLockPin_q),
    .mode_reached_flag_q(mode_reached_flag_q), .transmitter_ready_flag_q(transmitter_ready_flag_q), .receiver_ready_flag_q(receiver_ready_flag_q),
    .xtalEnable_q(xtalEnable_q), .synthEnable_q(synthEnable_q),
    .ampRegEnable_q(ampRegEnable_q), .ampRampEnable_q(ampRampEnable_q),
    .rxEnable_q(rxEnable_q), .rcOscOnly_q(rcOscOnly_q), .bitClockOut_q(bitClockOut_q),
    .txModData_q(txModData_q), .serialDataOut_q(serialDataOut_q),
    .serialDataOe_n_q(serialDataOe_n_q), .preambleOn_q(preOn), .packetActive_q(pktAct),
    .dataValid_q(dataVal));
  host_model host (.core_clk(core_clk), .bitClk(bitClockOut_q), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .serialDataIn(serialDataIn), .hung(hung));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    rcClkIn = 1'b0;
    forever #80 rcClkIn = ~rcClkIn;
  end
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    nChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic waitHi(input int k, output int c);
    for (c = 0; c < 9000 && flags[k] !== 1'b1; c++) @(posedge core_clk);
    if (c == 9000) begin
      mismatches++;
      close_out();
    end
  endtask
  always @(posedge hung) begin
    mismatches++;
    close_out();
  end
  // Lock arrives some cycles after the synthesizer is enabled
  always @(posedge core_clk) begin
    lockCnt <= synthEnable_q ? lockCnt + 1 : 0;
    synthLockIn <= lockCnt > 30;
    cyc <= cyc + 1;
    bcPrev <= bitClockOut_q;
    rv = $random(seed);
    if (cyc % 16 == 0) demodDataIn <= rv[0];
    if (rxChk && cyc % 16 == 8) check("rxData", serialDataOut_q, demodDataIn);
    if (txChk && bcPrev && !bitClockOut_q) check("txData", txModData_q, serialDataIn);
    if (psel && penable && pready && !pwrite)
      check("read", {pslverr, prdata}, expQ.pop_front());
  end
  initial begin
    {reset, synthLockIn, demodDataIn, txChk, rxChk, bcPrev, sigDet, txBegin} = 8'h80;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    waitHi(0, n);
    for (i = 0; i < 7; i++) rd(8'(i == 6 ? 32 : 4 * i), rstv[i]);
    wr(8'h00, 32'h0);
    repeat (8) @(posedge core_clk);
    check("sleep", {xtalEnable_q, synthEnable_q, rxEnable_q}, 0);
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h8);
    wr(8'h00, 32'hC);
    waitHi(3, n);
    check("txOrder", {pllLockPin_q, xtalEnable_q, synthEnable_q, ampRampEnable_q,
      bitClockOut_q, mode_reached_flag_q}, 6'b111000);
    waitHi(4, n1);
    check("rampOrder", {ampRegEnable_q, bitClockOut_q, transmitter_ready_flag_q}, 3'b100);
    waitHi(1, n);
    check("txDelay", n + n1 >= 1265 && n + n1 <= 1271, 1);
    repeat (2) @(posedge core_clk);
    check("transmitter_ready_flag", {mode_reached_flag_q, transmitter_ready_flag_q}, 2'b11);
    txChk = 1'b1;
    repeat (100) @(posedge core_clk);
    txChk = 1'b0;
    // A reserved code must leave transmit running
    wr(8'h00, 32'h14);
    repeat (20) @(posedge core_clk);
    check("resvd", {mode_reached_flag_q, transmitter_ready_flag_q}, 2'b11);
    rd(8'h00, 33'hC);
    // Channel hop of the transmitter through receive
    wr(8'h00, 32'h10);
    wr(8'h00, 32'hC);
    waitHi(1, n);
    check("hop", {mode_reached_flag_q, transmitter_ready_flag_q, rxEnable_q}, 3'b110);
    wr(8'h04, 32'h40010);
    repeat (2) @(posedge core_clk);
    check("preamble", {preOn, pktAct}, 2'b10);
    txBegin <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("packet", pktAct, 1);
    txBegin <= 1'b0;
    wr(8'h0C, 32'h0110010);
    for (i = 0; i < 2; i++) begin
      wr(8'h04, 32'h10 | (i << 16) | (i << 17));
      wr(8'h00, 32'h8);
      repeat (4) @(posedge core_clk);
      waitHi(0, n);
      wr(8'h00, 32'h10);
      waitHi(5, n);
      waitHi(2, n);
      check("rxDelay", n >= rxExp[i] - 3 && n <= rxExp[i] + 3, 1);
      check("valid", dataVal, i == 0);
    end
    rxChk = 1'b1;
    repeat (200) @(posedge core_clk);
    rxChk = 1'b0;
    check("synced", dataVal, 1);
    check("rxOe", serialDataOe_n_q, 0);
    wr(8'h00, 32'h80);
    repeat (4) @(posedge core_clk);
    check("direct", {xtalEnable_q, synthEnable_q, rxEnable_q, mode_reached_flag_q}, 4'b0001);
    wr(8'h00, 32'h4);
    repeat (4) @(posedge core_clk);
    waitHi(0, n);
    wr(8'h10, 32'h50202);
    wr(8'h00, 32'h44);
    waitHi(6, n);
    check("idle", {rxEnable_q, xtalEnable_q}, 0);
    waitHi(5, n);
    check("idleLen", n >= 370 && n <= 430, 1);
    sigDet <= 1'b1;
    waitHi(2, n);
    check("keep", {rxEnable_q, rcOscOnly_q, n < 20}, 3'b101);
    sigDet <= 1'b0;
    wr(8'h00, 32'h24);
    wr(8'h00, 32'h4);
    repeat (4) @(posedge core_clk);
    waitHi(0, n);
    check("abort", rcOscOnly_q, 0);
    close_out();
  end
endmodule
